// >>> common/fpo_defs.svh
`ifndef FPO_DEFS_SVH
`define FPO_DEFS_SVH

// Register byte addresses on the APB.
`define FPO_ADDR_PARAM0 12'h000
`define FPO_ADDR_PARAM1 12'h004
`define FPO_ADDR_PARAM2 12'h008
`define FPO_ADDR_PARAM3 12'h00c
`define FPO_ADDR_INDEX 12'h010
`define FPO_ADDR_STATUS 12'h014
`define FPO_ADDR_CONFIG 12'h018
`define FPO_ADDR_PFPROT 12'h01c
`define FPO_ADDR_EEPROT 12'h020
`define FPO_ADDR_PSTAT 12'h024
`define FPO_ADDR_ERCNFG 12'h028
`define FPO_ADDR_ERSTAT 12'h02c

// Field positions.
`define FPO_BIT_CCF 7
`define FPO_BIT_ACC_ERR 5
`define FPO_BIT_CMD_IE 7
`define FPO_BIT_OVRD 0
`define FPO_BIT_SFD 0

// Command encoding.
`define FPO_CMD_OVERRIDE 8'h13
`define FPO_KEY_INVALID 16'hffff
`define FPO_IDX_1 3'h1
`define FPO_IDX_2 3'h2
`define FPO_IDX_3 3'h3

// Reset values and timing.
`define FPO_PFPROT_RST 8'h00
`define FPO_EEPROT_RST 8'h00
`define FPO_INDEX_RST 3'h0
`define FPO_EXEC_CYCLES 4

`endif

// >>> common/fpo_pkg.sv
package fpo_pkg;

    typedef enum logic [2:0] {
        FPO_ST_IDLE = 3'b001,
        FPO_ST_EXEC = 3'b010,
        FPO_ST_DONE = 3'b100
    } fpo_state_e;

    typedef struct packed {
        logic [7:0] code;
        logic [1:0] sel;
        logic [15:0] key;
        logic [7:0] pf_val;
        logic [7:0] ee_val;
    } fpo_cmd_s;

    typedef struct packed {
        logic [7:0] pf;
        logic [7:0] ee;
    } fpo_prot_s;

endpackage

// >>> logic/fpo_top.sv
`timescale 1ns/10ps
`include "fpo_defs.svh"
module fpo_top
    import fpo_pkg::*;
#(
    parameter int EXEC_CYCLES = `FPO_EXEC_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] stored_key,
    input wire logic cmd_allowed,
    input wire logic single_fault_evt,
    input wire logic wait_mode,
    output logic cmd_irq,
    output logic err_irq,
    output logic wake_req,
    output logic [7:0] pflash_protect,
    output logic [7:0] eeprom_protect
);

    // Mapped registers are word aligned and end at the error status register.
    function automatic logic addr_known(input logic [11:0] a);
        return (a[1:0] == 2'b00) && (a <= `FPO_ADDR_ERSTAT);
    endfunction

    // Parameter words keep only their low half; the upper half reads as zero.
    logic [15:0] cmd_param_words_reg [4];
    logic [2:0] param_index_reg;
    logic cmd_complete_flag_reg;
    logic access_error_reg;
    logic cmd_complete_int_en_reg;
    logic single_fault_int_en_reg;
    logic single_fault_flag_reg;
    logic override_active_reg;
    fpo_prot_s prot_reg;
    fpo_prot_s save_reg;
    fpo_state_e state_reg;
    logic [7:0] exec_cnt_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic cmd_irq_reg;
    logic err_irq_reg;
    logic wake_reg;

    // Decoded command and the terms derived from it.
    fpo_cmd_s cmd;
    logic wr_en;
    logic launch;
    logic key_valid;
    logic key_match;
    logic restore;
    logic cmd_err;
    logic finish;

    // A write takes effect on the edge that ends its access phase.
    assign wr_en = psel && penable && pready_reg && pwrite && addr_known(paddr);
    assign launch = wr_en && (paddr == `FPO_ADDR_STATUS) && pwdata[`FPO_BIT_CCF]
        && cmd_complete_flag_reg;
    assign finish = (state_reg == FPO_ST_DONE);

    // Command fields as laid out in the four parameter words.
    assign cmd.code = cmd_param_words_reg[0][15:8];
    assign cmd.sel = cmd_param_words_reg[0][1:0];
    assign cmd.key = cmd_param_words_reg[1];
    assign cmd.pf_val = cmd_param_words_reg[2][7:0];
    assign cmd.ee_val = cmd_param_words_reg[3][7:0];

    assign key_valid = (cmd.key != `FPO_KEY_INVALID);
    // An erased stored key can never be matched.
    assign key_match = key_valid && (stored_key != `FPO_KEY_INVALID)
        && (cmd.key == stored_key);
    // Anything but a match asks for the saved values back.
    assign restore = !key_match;

    // Launch checks; any one of them makes the command end in an access error.
    always_comb begin
        cmd_err = 1'b0;
        if (cmd.code != `FPO_CMD_OVERRIDE) begin
            cmd_err = 1'b1;
        end
        if ((param_index_reg != `FPO_IDX_1) && (param_index_reg != `FPO_IDX_2)
            && (param_index_reg != `FPO_IDX_3)) begin
            cmd_err = 1'b1;
        end
        if (!cmd_allowed) begin
            cmd_err = 1'b1;
        end
        if (restore && !override_active_reg) begin
            cmd_err = 1'b1;
        end
        if ((cmd.sel == 2'b00) && ((param_index_reg == `FPO_IDX_2)
            || (param_index_reg == `FPO_IDX_3))) begin
            cmd_err = 1'b1;
        end
        if ((cmd.sel == 2'b00) && (param_index_reg == `FPO_IDX_1) && key_valid) begin
            cmd_err = 1'b1;
        end
    end

    // Command sequencing: launch, a fixed execution time, then completion.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= FPO_ST_IDLE;
            exec_cnt_reg <= 8'h00;
        end else begin
            unique case (state_reg)
                FPO_ST_IDLE: begin
                    if (launch) begin
                        state_reg <= FPO_ST_EXEC;
                        exec_cnt_reg <= 8'h00;
                    end
                end
                FPO_ST_EXEC: begin
                    if (exec_cnt_reg >= 8'(EXEC_CYCLES - 1)) begin
                        state_reg <= FPO_ST_DONE;
                    end else begin
                        exec_cnt_reg <= exec_cnt_reg + 8'h01;
                    end
                end
                FPO_ST_DONE: begin
                    state_reg <= FPO_ST_IDLE;
                end
                // An illegal state code falls back to idle.
                default: begin
                    state_reg <= FPO_ST_IDLE;
                end
            endcase
        end
    end

    // The complete flag drops at launch and rises again on the finishing edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_complete_flag_reg <= 1'b1;
        end else if (launch) begin
            cmd_complete_flag_reg <= 1'b0;
        end else if (finish) begin
            cmd_complete_flag_reg <= 1'b1;
        end
    end

    // Access error: set by a failing command, cleared by launch or write-one.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            access_error_reg <= 1'b0;
        end else if (finish && cmd_err) begin
            access_error_reg <= 1'b1;
        end else if (launch) begin
            access_error_reg <= 1'b0;
        end else if (wr_en && (paddr == `FPO_ADDR_STATUS) && pwdata[`FPO_BIT_ACC_ERR]) begin
            access_error_reg <= 1'b0;
        end
    end

    // A failing command leaves the override state as it was.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            override_active_reg <= 1'b0;
        end else if (finish && !cmd_err) begin
            override_active_reg <= key_match;
        end
    end

    // Single-entry save buffer, rewritten only by a successful override.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            save_reg <= '0;
        end else if (finish && !cmd_err && key_match) begin
            save_reg <= prot_reg;
        end
    end

    // Protection registers: command results take priority over direct writes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prot_reg.pf <= `FPO_PFPROT_RST;
            prot_reg.ee <= `FPO_EEPROT_RST;
        end else if (finish) begin
            if (!cmd_err) begin
                if (restore) begin
                    prot_reg <= save_reg;
                end else begin
                    if (cmd.sel[0]) begin
                        prot_reg.pf <= cmd.pf_val;
                    end
                    if (cmd.sel[1]) begin
                        prot_reg.ee <= cmd.ee_val;
                    end
                end
            end
        end else if (wr_en && cmd_complete_flag_reg) begin
            if (paddr == `FPO_ADDR_PFPROT) begin
                prot_reg.pf <= pwdata[7:0];
            end
            if (paddr == `FPO_ADDR_EEPROT) begin
                prot_reg.ee <= pwdata[7:0];
            end
        end
    end

    // Parameter words and index are frozen while a command runs.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 4; i++) begin
                cmd_param_words_reg[i] <= 16'h0000;
            end
            param_index_reg <= `FPO_INDEX_RST;
        end else if (wr_en && cmd_complete_flag_reg) begin
            if (paddr == `FPO_ADDR_PARAM0) begin
                cmd_param_words_reg[0] <= pwdata[15:0];
            end
            if (paddr == `FPO_ADDR_PARAM1) begin
                cmd_param_words_reg[1] <= pwdata[15:0];
            end
            if (paddr == `FPO_ADDR_PARAM2) begin
                cmd_param_words_reg[2] <= pwdata[15:0];
            end
            if (paddr == `FPO_ADDR_PARAM3) begin
                cmd_param_words_reg[3] <= pwdata[15:0];
            end
            if (paddr == `FPO_ADDR_INDEX) begin
                param_index_reg <= pwdata[2:0];
            end
        end
    end

    // Interrupt enables may be written at any time, even while a command runs.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_complete_int_en_reg <= 1'b0;
            single_fault_int_en_reg <= 1'b0;
        end else if (wr_en) begin
            if (paddr == `FPO_ADDR_CONFIG) begin
                cmd_complete_int_en_reg <= pwdata[`FPO_BIT_CMD_IE];
            end
            if (paddr == `FPO_ADDR_ERCNFG) begin
                single_fault_int_en_reg <= pwdata[`FPO_BIT_SFD];
            end
        end
    end

    // A fault in the same cycle as the write-one clear keeps the flag set.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            single_fault_flag_reg <= 1'b0;
        end else if (single_fault_evt) begin
            single_fault_flag_reg <= 1'b1;
        end else if (wr_en && (paddr == `FPO_ADDR_ERSTAT) && pwdata[`FPO_BIT_SFD]) begin
            single_fault_flag_reg <= 1'b0;
        end
    end

    // Interrupt and wake requests are registered so each comes from a flip-flop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_irq_reg <= 1'b0;
            err_irq_reg <= 1'b0;
            wake_reg <= 1'b0;
        end else begin
            cmd_irq_reg <= cmd_complete_flag_reg && cmd_complete_int_en_reg;
            err_irq_reg <= single_fault_flag_reg && single_fault_int_en_reg;
            wake_reg <= wait_mode && cmd_complete_flag_reg && cmd_complete_int_en_reg;
        end
    end

    // APB: answer prepared in the setup cycle, ready in the first access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= psel && !penable;
            // Unmapped or misaligned addresses answer with an error and read as zero.
            pslverr_reg <= psel && !penable && !addr_known(paddr);
            prdata_reg <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                unique case (paddr)
                    `FPO_ADDR_PARAM0: prdata_reg <= {16'h0000, cmd_param_words_reg[0]};
                    `FPO_ADDR_PARAM1: prdata_reg <= {16'h0000, cmd_param_words_reg[1]};
                    `FPO_ADDR_PARAM2: prdata_reg <= {16'h0000, cmd_param_words_reg[2]};
                    `FPO_ADDR_PARAM3: prdata_reg <= {16'h0000, cmd_param_words_reg[3]};
                    `FPO_ADDR_INDEX: prdata_reg <= {29'h0, param_index_reg};
                    `FPO_ADDR_STATUS: prdata_reg <= {24'h0, cmd_complete_flag_reg, 1'b0,
                        access_error_reg, 5'h00};
                    `FPO_ADDR_CONFIG: prdata_reg <= {24'h0, cmd_complete_int_en_reg, 7'h00};
                    `FPO_ADDR_PFPROT: prdata_reg <= {24'h0, prot_reg.pf};
                    `FPO_ADDR_EEPROT: prdata_reg <= {24'h0, prot_reg.ee};
                    `FPO_ADDR_PSTAT: prdata_reg <= {31'h0, override_active_reg};
                    `FPO_ADDR_ERCNFG: prdata_reg <= {31'h0, single_fault_int_en_reg};
                    `FPO_ADDR_ERSTAT: prdata_reg <= {31'h0, single_fault_flag_reg};
                    default: prdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Outputs come straight from their registers.
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign cmd_irq = cmd_irq_reg;
    assign err_irq = err_irq_reg;
    assign wake_req = wake_reg;
    assign pflash_protect = prot_reg.pf;
    assign eeprom_protect = prot_reg.ee;

endmodule

// >>> tb/fpo_properties.sv
`timescale 1ns/10ps
`include "fpo_defs.svh"
module fpo_properties
    import fpo_pkg::*;
#(
    parameter int EXEC_CYCLES = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [15:0] stored_key,
    input wire logic cmd_allowed,
    input wire logic single_fault_evt,
    input wire logic wait_mode,
    input wire logic cmd_irq,
    input wire logic err_irq,
    input wire logic wake_req,
    input wire logic [7:0] pflash_protect,
    input wire logic [7:0] eeprom_protect
);
    logic wr;
    logic [15:0] cnt_h;
    logic cmd_ie_h, sfde_h, sfd_h, touched_h;
    assign wr = psel && penable && pready && pwrite;
    // The complete flag is low exactly while cnt_h is non-zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_h <= 16'h0000;
        end else if (wr && paddr == `FPO_ADDR_STATUS && pwdata[7] && cnt_h == 16'h0000) begin
            cnt_h <= 16'(EXEC_CYCLES + 1);
        end else if (cnt_h != 16'h0000) begin
            cnt_h <= cnt_h - 16'h0001;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_ie_h <= 1'h0;
            sfde_h <= 1'h0;
        end else if (wr && paddr == `FPO_ADDR_CONFIG) begin
            cmd_ie_h <= pwdata[7];
        end else if (wr && paddr == `FPO_ADDR_ERCNFG) begin
            sfde_h <= pwdata[0];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sfd_h <= 1'h0;
        end else if (single_fault_evt) begin
            sfd_h <= 1'h1;
        end else if (wr && paddr == `FPO_ADDR_ERSTAT && pwdata[0]) begin
            sfd_h <= 1'h0;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            touched_h <= 1'h0;
        end else begin
            touched_h <= touched_h | wr;
        end
    end
    sequence stat_rd_s;
        psel && !penable && !pwrite && paddr == `FPO_ADDR_STATUS ##1 penable && pready;
    endsequence
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    cmd_irq_a:
        assert property (cmd_irq == $past(cnt_h == 16'h0000 && cmd_ie_h))
        else $error("command interrupt does not follow flag and enable");
    wake_req_a:
        assert property (wake_req == $past(wait_mode && cnt_h == 16'h0000 && cmd_ie_h))
        else $error("wake request does not follow wait and command interrupt");
    err_irq_a:
        assert property (err_irq == $past(sfd_h && sfde_h))
        else $error("error interrupt does not follow fault flag and enable");
    busy_hold_a:
        assert property (cnt_h > 16'h0001 |=> $stable(pflash_protect) && $stable(eeprom_protect))
        else $error("protection moved while a command was busy");
    status_read_a:
        assert property (stat_rd_s |-> prdata[7] == ($past(cnt_h) == 16'h0000))
        else $error("complete flag read back wrong");
    pf_change_a:
        assert property ($changed(pflash_protect) |-> $past(cnt_h) == 16'h0001
            || ($past(wr && paddr == `FPO_ADDR_PFPROT && cnt_h == 16'h0000)
            && pflash_protect == $past(pwdata[7:0])))
        else $error("flash protection changed without cause");
    ee_change_a:
        assert property ($changed(eeprom_protect) |-> $past(cnt_h) == 16'h0001
            || ($past(wr && paddr == `FPO_ADDR_EEPROT && cnt_h == 16'h0000)
            && eeprom_protect == $past(pwdata[7:0])))
        else $error("eeprom protection changed without cause");
    reset_prot_a:
        assert property (!touched_h |-> pflash_protect == 8'h00 && eeprom_protect == 8'h00)
        else $error("protection not at reset value");
endmodule

bind fpo_top fpo_properties #(.EXEC_CYCLES(EXEC_CYCLES)) i_fpo_properties (.*);

// >>> tb/flash_protection_override_test.sv
`timescale 1ns/10ps
`include "fpo_defs.svh"
module flash_protection_override_test;
    import fpo_pkg::*;
    localparam logic [2:0] EIDX [6] = '{3'h0, 3'h4, 3'h7, 3'h2, 3'h3, 3'h1};
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, r32;
    logic [15:0] stored_key = 16'h5a3c, kk;
    logic cmd_allowed = 1'h1, single_fault_evt = 1'h0, wait_mode = 1'h0;
    logic pready, pslverr, cmd_irq, err_irq, wake_req, ok_err, e_act;
    logic [7:0] pflash_protect, eeprom_protect, e_pf, e_ee, s_pf, s_ee;
    logic [2:0] ix;
    int n_errors = 0, n_compared = 0, cyc = 0;
    always #50 pclk = ~pclk;
    fpo_top #(.EXEC_CYCLES(3)) i_fpo_top (.*);
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 6000) begin
            n_errors++;
            final_report();
        end
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        rd = prdata;
        ok_err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    // Returns {access error, key match} for the command about to launch.
    function automatic logic [1:0] outcome(logic [7:0] c, logic [1:0] s, logic [15:0] k,
                                           logic [2:0] x);
        logic vk, m;
        vk = k !== 16'hffff;
        m = vk && k === stored_key && stored_key !== 16'hffff;
        return {!(x inside {3'h1, 3'h2, 3'h3}) || !cmd_allowed || c !== 8'h13
            || (s == 2'h0 && (x != 3'h1 || vk)) || (!m && !e_act), m};
    endfunction
    task automatic cmd(logic [7:0] c, logic [1:0] s, logic [15:0] k, logic [7:0] pf,
                       logic [7:0] ee, logic [2:0] x);
        logic [1:0] r;
        apb(1'h1, `FPO_ADDR_PARAM0, {16'h0, c, 6'h0, s});
        apb(1'h1, `FPO_ADDR_PARAM1, {16'h0, k});
        apb(1'h1, `FPO_ADDR_PARAM2, {24'h0, pf});
        apb(1'h1, `FPO_ADDR_PARAM3, {24'h0, ee});
        apb(1'h1, `FPO_ADDR_INDEX, {29'h0, x});
        apb(1'h1, `FPO_ADDR_STATUS, 32'h80);
        // Mode and stored key have settled by now, as the design sees them.
        r = outcome(c, s, k, x);
        do begin
            apb(1'h0, `FPO_ADDR_STATUS, 32'h0);
        end while (rd[7] !== 1'h1);
        if (!r[1] && r[0]) begin
            {s_pf, s_ee} = {e_pf, e_ee};
            e_pf = s[0] ? pf : e_pf;
            e_ee = s[1] ? ee : e_ee;
        end else if (!r[1]) begin
            {e_pf, e_ee} = {s_pf, s_ee};
        end
        e_act = r[1] ? e_act : r[0];
        check(rd & 32'h20, {26'h0, r[1], 5'h0});
        check({16'h0, pflash_protect, eeprom_protect}, {16'h0, e_pf, e_ee});
        apb(1'h0, `FPO_ADDR_PSTAT, 32'h0);
        check(rd, {31'h0, e_act});
    endtask
    task automatic pulse_fault(input logic en, input logic exp);
        apb(1'h1, `FPO_ADDR_ERCNFG, {31'h0, en});
        single_fault_evt <= 1'h1;
        @(posedge pclk);
        single_fault_evt <= 1'h0;
        repeat (3) @(posedge pclk);
        check({31'h0, err_irq}, {31'h0, exp});
        apb(1'h0, `FPO_ADDR_ERSTAT, 32'h0);
        check(rd, 32'h1);
        apb(1'h1, `FPO_ADDR_ERSTAT, 32'h1);
        repeat (3) @(posedge pclk);
        check({31'h0, err_irq}, 32'h0);
    endtask
    initial begin
        r32 = $urandom(32'h21a66d84);
        {e_pf, e_ee, s_pf, s_ee, e_act} = 33'h0;
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, `FPO_ADDR_STATUS, 32'h0);
        check(rd, 32'h80);
        apb(1'h0, `FPO_ADDR_PSTAT, 32'h0);
        check(rd, 32'h0);
        apb(1'h0, 12'h030, 32'h0);
        check({31'h0, ok_err}, 32'h1);
        $display("test reset done");
        cmd(8'h13, 2'h3, 16'h1111, 8'h55, 8'h66, 3'h3);
        cmd(8'h13, 2'h0, 16'hffff, 8'h00, 8'h00, 3'h1);
        cmd(8'h13, 2'h3, 16'h5a3c, 8'hff, 8'h5c, 3'h3);
        for (int k = 0; k < 6; k++) begin
            cmd(8'h13, k < 3 ? 2'h3 : 2'h0, 16'h5a3c, 8'h11, 8'h22, EIDX[k]);
        end
        cmd(8'h12, 2'h3, 16'h5a3c, 8'h11, 8'h22, 3'h3);
        cmd_allowed <= 1'h0;
        cmd(8'h13, 2'h3, 16'h5a3c, 8'h33, 8'h44, 3'h3);
        cmd_allowed <= 1'h1;
        $display("test errors done");
        apb(1'h1, `FPO_ADDR_PFPROT, 32'ha5);
        e_pf = 8'ha5;
        apb(1'h0, `FPO_ADDR_PFPROT, 32'h0);
        check(rd, 32'ha5);
        cmd(8'h13, 2'h2, 16'h5a3c, 8'h01, 8'h3c, 3'h3);
        apb(1'h1, `FPO_ADDR_EEPROT, 32'h77);
        e_ee = 8'h77;
        cmd(8'h13, 2'h3, 16'h0001, 8'h00, 8'h00, 3'h3);
        cmd(8'h13, 2'h1, 16'h5a3c, 8'h12, 8'h99, 3'h3);
        stored_key <= 16'hffff;
        cmd(8'h13, 2'h3, 16'h5a3c, 8'h21, 8'h43, 3'h3);
        cmd(8'h13, 2'h3, 16'h2222, 8'h21, 8'h43, 3'h3);
        stored_key <= 16'h5a3c;
        $display("test restore done");
        apb(1'h1, `FPO_ADDR_CONFIG, 32'h80);
        wait_mode <= 1'h1;
        cmd(8'h13, 2'h3, 16'h5a3c, 8'h0f, 8'hf0, 3'h3);
        check({30'h0, cmd_irq, wake_req}, 32'h3);
        apb(1'h1, `FPO_ADDR_CONFIG, 32'h0);
        repeat (2) @(posedge pclk);
        check({30'h0, cmd_irq, wake_req}, 32'h0);
        wait_mode <= 1'h0;
        pulse_fault(1'h1, 1'h1);
        pulse_fault(1'h0, 1'h0);
        $display("test interrupts done");
        for (int k = 0; k < 16; k++) begin
            r32 = $urandom;
            kk = r32[1:0] == 2'h0 ? 16'hffff : r32[2] ? stored_key : r32[31:16];
            ix = r32[5:3] == 3'h0 ? r32[8:6] : 3'h3;
            kk = (ix != 3'h3 && kk == stored_key) ? ~kk : kk;
            if (r32[14]) begin
                apb(1'h1, `FPO_ADDR_PFPROT, r32);
                e_pf = r32[7:0];
            end
            cmd(r32[11:9] == 3'h0 ? r32[19:12] : 8'h13, r32[13:12], kk, r32[23:16],
                r32[31:24], ix);
        end
        $display("test random done");
        final_report();
    end
endmodule
